/* logic/cif_chan_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cif_chan_if;
  logic [3:0] code;  // function code of this input
  logic       qual;  // qualified asserted state
  logic       fire;  // one-cycle pulse when qual rises
  modport chan (input code, output qual, output fire);
  modport ctrl (output code, input qual, input fire);
endinterface
`default_nettype wire

/* logic/cif_pkg.sv */
`default_nettype none
package cif_pkg;

  typedef enum logic [3:0] {
    CIF_FN_OFF     = 4'h0,
    CIF_FN_WF_HI   = 4'h1,
    CIF_FN_WF_LO   = 4'h2,
    CIF_FN_AUX_HI  = 4'h3,
    CIF_FN_AUX_LO  = 4'h4,
    CIF_FN_DIS_HI  = 4'h5,
    CIF_FN_DIS_LO  = 4'h6,
    CIF_FN_DRS_HI  = 4'h7,
    CIF_FN_DRS_LO  = 4'h8,
    CIF_FN_RST_HI  = 4'h9,
    CIF_FN_DNE_HI  = 4'hE,
    CIF_FN_DNE_LO  = 4'hF
  } cif_func_t;

  typedef logic [15:0] cif_press_t;

  // codes outside the handled set (low pressure 10..13) act as no function
  function automatic logic cif_used(input logic [3:0] c);
    return (c != 4'h0) && !(c >= 4'hA && c <= 4'hD);
  endfunction

  function automatic logic cif_active_low(input logic [3:0] c);
    return (c == 4'h2) || (c == 4'h4) || (c == 4'h6) || (c == 4'h8) || (c == 4'hF);
  endfunction

  function automatic logic cif_is_wf(input logic [3:0] c);
    return (c == 4'h1) || (c == 4'h2);
  endfunction

  function automatic logic cif_is_aux(input logic [3:0] c);
    return (c == 4'h3) || (c == 4'h4);
  endfunction

  function automatic logic cif_is_dis(input logic [3:0] c);
    return ((c >= 4'h5) && (c <= 4'h8)) || (c == 4'hE) || (c == 4'hF);
  endfunction

  function automatic logic cif_is_dis_err(input logic [3:0] c);
    return (c >= 4'h5) && (c <= 4'h8);
  endfunction

  function automatic logic cif_is_rst(input logic [3:0] c);
    return (c == 4'h7) || (c == 4'h8) || (c == 4'h9);
  endfunction

endpackage
`default_nettype wire

/* logic/cif_qual.sv */
`timescale 1ns/10ps
`default_nettype none
module cif_qual #(
  parameter int ON_TICKS  = 1000,
  parameter int OFF_LONG  = 30000,
  parameter int CW        = 16
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  tick,
  input  wire logic  pin,
  cif_chan_if.chan   ch
);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          qual;
    logic          fire;
    logic [CW-1:0] cnt;
  } cif_qual_st_t;

  cif_qual_st_t st_reg;
  cif_qual_st_t st_next;
  logic         asserted;
  logic [CW-1:0] limit;

  // level after polarity; the release time is long only for the float function
  always_comb begin
    asserted = st_reg.s2 ^ cif_pkg::cif_active_low(ch.code);
    limit    = (st_reg.qual && cif_pkg::cif_is_wf(ch.code)) ? CW'(OFF_LONG - 1) : CW'(ON_TICKS - 1);
    st_next      = st_reg;
    st_next.s1   = pin;
    st_next.s2   = st_reg.s1;
    st_next.fire = 1'b0;
    if (!cif_pkg::cif_used(ch.code)) begin
      st_next.qual = 1'b0;
      st_next.cnt  = '0;
    end else if (asserted == st_reg.qual) begin
      st_next.cnt = '0;
    end else if (tick) begin
      if (st_reg.cnt == limit) begin
        st_next.qual = asserted;
        st_next.fire = asserted;
        st_next.cnt  = '0;
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.qual = st_reg.qual;
  assign ch.fire = st_reg.fire;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_CODE_ZERO: assert property ((ch.code == 4'h0) |=> !ch.qual)
    else $error("disabled input drove a function");
  AST_ON_TIME: assert property ($rose(ch.qual) |-> $past(st_reg.cnt) == CW'(ON_TICKS - 1) && $past(tick))
    else $error("input qualified before the on time");
  AST_WF_RELEASE: assert property ($fell(ch.qual) && $past(cif_pkg::cif_is_wf(ch.code))
                                   && cif_pkg::cif_is_wf(ch.code) |-> $past(st_reg.cnt) == CW'(OFF_LONG - 1))
    else $error("float released before the long off time");
  AST_RESTART: assert property ((asserted == st_reg.qual) |=> st_reg.cnt == '0)
    else $error("qualify counter not restarted");

endmodule
`default_nettype wire

/* logic/cif_regs.svh */
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH

// register byte offsets on the AXI4-Lite port
`define CIF_OFF_CODES   8'h00
`define CIF_OFF_MAIN_SP 8'h04
`define CIF_OFF_AUX0    8'h08
`define CIF_OFF_STATUS  8'h14

// reset values: input 0 float, input 1 aux setpoint, input 2 disable
`define CIF_CODES_RST   12'h531
`define CIF_MAIN_SP_RST 16'h0000
`define CIF_AUX_RST     16'h0000

// status register field positions
`define CIF_ST_WF       0
`define CIF_ST_DIS      1
`define CIF_ST_AUX      2
`define CIF_ST_DIS_ERR  3
`define CIF_ST_QUAL_LSB 8
`define CIF_ST_TGT_LSB  16

// time base
`define CIF_CLK_NS      5
`define CIF_TICK_NS     1000000
`define CIF_TICK_MS     1
`define CIF_T_ON_MS     1000
`define CIF_T_WF_OFF_MS 30000
`define CIF_TICK_CYCLES (`CIF_TICK_NS / `CIF_CLK_NS)
`define CIF_ON_TICKS    (`CIF_T_ON_MS / `CIF_TICK_MS)
`define CIF_WF_TICKS    (`CIF_T_WF_OFF_MS / `CIF_TICK_MS)

`endif

/* logic/cif_top.sv */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cif_regs.svh"
module cif_top #(
  parameter int N_IN        = 3,
  parameter int AW          = 8,
  parameter int TICK_CYCLES = `CIF_TICK_CYCLES,
  parameter int ON_TICKS    = `CIF_ON_TICKS,
  parameter int WF_TICKS    = `CIF_WF_TICKS
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [N_IN-1:0]        in_pin,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [AW-1:0]          s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [AW-1:0]          s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        water_failure_flag,
  output logic                        system_disable_flag,
  output logic                        disable_error_flag,
  output logic                        aux_setpoint_active_flag,
  output logic                        system_block,
  output logic                        block_reset_pulse,
  output logic [15:0]                 target_setpoint
);

  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  typedef struct packed {
    logic [17:0]        tick_cnt;
    logic               tick;
    logic               aw_rdy;
    logic               w_rdy;
    logic               aw_got;
    logic               w_got;
    logic [AW-1:0]      awaddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               ar_rdy;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [4*N_IN-1:0]  codes;
    logic [15:0]        main_sp;
    logic [16*N_IN-1:0] aux;
    logic               wf;
    logic               dis;
    logic               dis_err;
    logic               aux_act;
    logic               block;
    logic               rst_pulse;
    logic [15:0]        target;
  } cif_top_st_t;

  cif_top_st_t     st_reg;
  cif_top_st_t     st_next;
  logic [N_IN-1:0] qual_vec;
  logic [N_IN-1:0] wf_vec;
  logic [N_IN-1:0] aux_vec;
  logic [N_IN-1:0] dis_vec;
  logic [N_IN-1:0] dis_err_vec;
  logic [N_IN-1:0] rst_vec;

  cif_chan_if ch [N_IN] ();

  // one qualifier per input, each with its own function code
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign ch[gi].code = st_reg.codes[4*gi +: 4];
      cif_qual #(
        .ON_TICKS (ON_TICKS),
        .OFF_LONG (WF_TICKS),
        .CW       (16)
      ) u_qual (
        .clk  (clk),
        .nrst (nrst),
        .tick (st_reg.tick),
        .pin  (in_pin[gi]),
        .ch   (ch[gi])
      );
      assign qual_vec[gi]    = ch[gi].qual;
      assign wf_vec[gi]      = ch[gi].qual && cif_pkg::cif_is_wf(ch[gi].code);
      assign aux_vec[gi]     = ch[gi].qual && cif_pkg::cif_is_aux(ch[gi].code);
      assign dis_vec[gi]     = ch[gi].qual && cif_pkg::cif_is_dis(ch[gi].code);
      assign dis_err_vec[gi] = ch[gi].qual && cif_pkg::cif_is_dis_err(ch[gi].code);
      assign rst_vec[gi]     = ch[gi].fire && cif_pkg::cif_is_rst(ch[gi].code);
    end
  endgenerate

  // byte-lane merge for AXI write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0]  m;
    logic         hit;
    logic         found;
    logic [15:0]  best;
    m    = '0;
    hit  = 1'b0;
    found = 1'b0;
    best = st_reg.main_sp;
    st_next = st_reg;

    // slow tick: long divide, so a simulation shortens it by parameter
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == 18'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 18'h00001;
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && st_reg.aw_rdy) begin
      st_next.aw_got = 1'b1;
      st_next.aw_rdy = 1'b0;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.w_rdy) begin
      st_next.w_got = 1'b1;
      st_next.w_rdy = 1'b0;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OK;
      if (st_reg.awaddr == AW'(`CIF_OFF_CODES)) begin
        m = merge(32'(st_reg.codes), st_reg.wdata, st_reg.wstrb);
        st_next.codes = m[4*N_IN-1:0];
      end else if (st_reg.awaddr == AW'(`CIF_OFF_MAIN_SP)) begin
        m = merge(32'(st_reg.main_sp), st_reg.wdata, st_reg.wstrb);
        st_next.main_sp = m[15:0];
      end else if (st_reg.awaddr == AW'(`CIF_OFF_STATUS)) begin
        hit = 1'b1; // read-only, write ignored
      end else begin
        for (int i = 0; i < N_IN; i++) begin
          if (st_reg.awaddr == AW'(`CIF_OFF_AUX0 + 4 * i)) begin
            m   = merge(32'(st_reg.aux[16*i +: 16]), st_reg.wdata, st_reg.wstrb);
            hit = 1'b1;
            st_next.aux[16*i +: 16] = m[15:0];
          end
        end
        if (!hit) begin
          st_next.bresp = RESP_ERR;
        end
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy  = 1'b1;
    end

    // read: answer registered one cycle after the address is taken
    if (s_axi_arvalid && st_reg.ar_rdy) begin
      st_next.ar_rdy = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OK;
      st_next.rdata  = '0;
      if (s_axi_araddr == AW'(`CIF_OFF_CODES)) begin
        st_next.rdata = 32'(st_reg.codes);
      end else if (s_axi_araddr == AW'(`CIF_OFF_MAIN_SP)) begin
        st_next.rdata = 32'(st_reg.main_sp);
      end else if (s_axi_araddr == AW'(`CIF_OFF_STATUS)) begin
        st_next.rdata[`CIF_ST_WF]      = st_reg.wf;
        st_next.rdata[`CIF_ST_DIS]     = st_reg.dis;
        st_next.rdata[`CIF_ST_AUX]     = st_reg.aux_act;
        st_next.rdata[`CIF_ST_DIS_ERR] = st_reg.dis_err;
        st_next.rdata[`CIF_ST_QUAL_LSB +: N_IN] = qual_vec;
        st_next.rdata[`CIF_ST_TGT_LSB +: 16]    = st_reg.target;
      end else begin
        st_next.rresp = RESP_ERR;
        for (int i = 0; i < N_IN; i++) begin
          if (s_axi_araddr == AW'(`CIF_OFF_AUX0 + 4 * i)) begin
            st_next.rdata = 32'(st_reg.aux[16*i +: 16]);
            st_next.rresp = RESP_OK;
          end
        end
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end

    // lowest active auxiliary pressure replaces the main setpoint; own flag so a
    // register write in the same cycle cannot disturb the search
    for (int i = 0; i < N_IN; i++) begin
      if (aux_vec[i] && (!found || st_reg.aux[16*i +: 16] < best)) begin
        best  = st_reg.aux[16*i +: 16];
        found = 1'b1;
      end
    end
    st_next.target    = aux_vec != '0 ? best : st_reg.main_sp;
    st_next.wf        = |wf_vec;
    st_next.aux_act   = |aux_vec;
    st_next.dis       = |dis_vec;
    st_next.dis_err   = |dis_err_vec; // codes 14/15 keep this low
    st_next.block     = (|wf_vec) || (|dis_vec);
    st_next.rst_pulse = |rst_vec;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg         <= '0;
      st_reg.aw_rdy  <= 1'b1;
      st_reg.w_rdy   <= 1'b1;
      st_reg.ar_rdy  <= 1'b1;
      st_reg.codes   <= (4*N_IN)'(`CIF_CODES_RST);
      st_reg.main_sp <= `CIF_MAIN_SP_RST;
      st_reg.aux     <= {N_IN{`CIF_AUX_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready            = st_reg.aw_rdy;
  assign s_axi_wready             = st_reg.w_rdy;
  assign s_axi_bvalid             = st_reg.bvalid;
  assign s_axi_bresp              = st_reg.bresp;
  assign s_axi_arready            = st_reg.ar_rdy;
  assign s_axi_rvalid             = st_reg.rvalid;
  assign s_axi_rdata              = st_reg.rdata;
  assign s_axi_rresp              = st_reg.rresp;
  assign water_failure_flag       = st_reg.wf;
  assign system_disable_flag      = st_reg.dis;
  assign disable_error_flag       = st_reg.dis_err;
  assign aux_setpoint_active_flag = st_reg.aux_act;
  assign system_block             = st_reg.block;
  assign block_reset_pulse        = st_reg.rst_pulse;
  assign target_setpoint          = st_reg.target;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_WF_FLAG: assert property ((|wf_vec) |=> water_failure_flag && system_block)
    else $error("water failure flag missing while a float is active");
  AST_DIS_FLAG: assert property ((dis_vec == '0) |=> !system_disable_flag)
    else $error("disable flag held with no disable input");
  AST_AUX_FLAG: assert property ((|aux_vec) |=> aux_setpoint_active_flag)
    else $error("aux flag missing while an aux input is active");
  AST_MAIN_SP: assert property ((aux_vec == '0) |=> target_setpoint == $past(st_reg.main_sp))
    else $error("target is not the main setpoint");
  AST_RST_PULSE: assert property (block_reset_pulse |-> $past(|rst_vec) ##1 !block_reset_pulse)
    else $error("block reset pulse without cause or too long");
  AST_CODE9_QUIET: assert property ((st_reg.codes[3:0] == 4'h9) && (dis_vec[N_IN-1:1] == '0)
                                    && (wf_vec[N_IN-1:1] == '0) |=> !system_disable_flag && !system_block)
    else $error("code 9 drove a disable");

  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_ast
      AST_AUX_MIN: assert property (aux_vec[gi] |=> target_setpoint <= $past(st_reg.aux[16*gi +: 16]))
        else $error("target above an active aux pressure");
    end
  endgenerate

endmodule
`default_nettype wire

/* tb/cif_contacts.sv */
`timescale 1ns/10ps
`default_nettype none
// dry contacts on the auxiliary inputs; each change of level bounces for a few
// clocks, so the device must not qualify on the first edge it sees
module cif_contacts #(
  parameter int N      = 3,
  parameter int BOUNCE = 3
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] cmd,
  output logic      [N-1:0] contact
);
  logic [N-1:0] last;
  int           cnt [N] = '{default: 0};

  // contacts are always driven: a closed or open switch is a defined level
  initial begin
    contact = '0;
    last = '0;
  end

  // new level first, then toggle until the bounce count runs out
  always @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (cmd[i] != last[i]) begin
        last[i] <= cmd[i];
        contact[i] <= cmd[i];
        cnt[i] <= BOUNCE;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        contact[i] <= (cnt[i] == 1) ? last[i] : ~contact[i];
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_configurable_input_functions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cif_regs.svh"
module test_configurable_input_functions;
  // shortened time base so the long qualifications fit the run
  localparam int T      = 4;
  localparam int ON     = 3;
  localparam int WF     = 8;
  localparam int EARLY  = (ON - 1) * T;
  localparam int Q      = ON * T + 12;
  localparam int WEARLY = (WF - 1) * T;
  localparam int WQ     = WF * T + 12;
  localparam logic [3:0] CODE_LIST [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE, 4'hF};

  logic        clk           = 1'b0;
  logic        nrst          = 1'b0;
  logic [2:0]  cmd           = 3'h0;
  logic [2:0]  in_pin;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        water_failure_flag, system_disable_flag, disable_error_flag;
  logic        aux_setpoint_active_flag, system_block, block_reset_pulse;
  logic [15:0] target_setpoint;
  logic [4:0]  fl;
  int          failures      = 0;
  int          checks_done   = 0;
  int          pulse_cycles  = 0;
  int          p0;
  logic [3:0]  c;
  logic        low;

  // flag bundle: block, disable error, aux, disable, water failure
  assign fl = {system_block, disable_error_flag, aux_setpoint_active_flag, system_disable_flag, water_failure_flag};

  always #2.5 clk = ~clk;

  // a stuck pulse would count more than one cycle per qualification
  always @(posedge clk) if (block_reset_pulse === 1'b1) pulse_cycles <= pulse_cycles + 1;

  cif_contacts #(.N(3), .BOUNCE(3)) u_contacts (.clk(clk), .cmd(cmd), .contact(in_pin));

  cif_top #(.TICK_CYCLES(T), .ON_TICKS(ON), .WF_TICKS(WF)) dut (
    .clk(clk), .nrst(nrst), .in_pin(in_pin),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .water_failure_flag(water_failure_flag), .system_disable_flag(system_disable_flag),
    .disable_error_flag(disable_error_flag), .aux_setpoint_active_flag(aux_setpoint_active_flag),
    .system_block(system_block), .block_reset_pulse(block_reset_pulse), .target_setpoint(target_setpoint)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // address and data offered together, each dropped when taken; bready held high
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no local limit: only the watchdog ends a wait
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
    end while (s_axi_bvalid !== 1'b1);
    check("write resp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(nm, d, e);
    check({nm, " resp"}, 32'(r), 32'(er));
  endtask

  // flags must still hold the old pattern at lo and the new one by hi
  task automatic settle(input int lo, input int hi, input logic [4:0] eb, input logic [4:0] ea, input string nm);
    repeat (lo) @(posedge clk);
    check({nm, " early"}, 32'(fl), 32'(eb));
    repeat (hi - lo) @(posedge clk);
    check(nm, 32'(fl), 32'(ea));
  endtask

  // inputs 0 and 2 together, then 0 released, then 2 released
  task automatic multi(input logic [31:0] cw, input logic [4:0] both, input logic [4:0] one, input int lo,
                       input int hi, input string nm);
    axi_write(`CIF_OFF_CODES, cw, 2'b00);
    cmd <= 3'b101;
    settle(EARLY, Q, 5'h00, both, nm);
    cmd <= 3'b100;
    settle(lo, hi, both, one, nm);
    cmd <= 3'b000;
    settle(lo, hi, one, 5'h00, nm);
  endtask

  // expected flags while an input with this code is qualified
  function automatic logic [4:0] act_flags(input logic [3:0] k);
    case (k)
      4'h1, 4'h2: return 5'b10001;
      4'h3, 4'h4: return 5'b00100;
      4'h5, 4'h6, 4'h7, 4'h8: return 5'b11010;
      4'hE, 4'hF: return 5'b10010;
      default: return 5'b00000;
    endcase
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // a hang costs far more than the whole sequence, about 1400 cycles
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("flags after reset", 32'(fl), 32'h0);
    rd_chk(`CIF_OFF_CODES, 32'h0000_0531, 2'b00, "codes reset");
    rd_chk(`CIF_OFF_STATUS, 32'h0, 2'b00, "status reset");
    rd_chk(8'h40, 32'h0, 2'b10, "unmapped read");
    axi_write(8'h40, 32'hFFFF_FFFF, 2'b10);
    axi_write(`CIF_OFF_STATUS, 32'hFFFF_FFFF, 2'b00);
    rd_chk(`CIF_OFF_STATUS, 32'h0, 2'b00, "status read only");
    // setpoints: aux one 0x0300, two 0x0200, three 0x0100, main 0x0500
    axi_write(`CIF_OFF_MAIN_SP, 32'h0000_0500, 2'b00);
    for (int i = 0; i < 3; i++) axi_write(`CIF_OFF_AUX0 + 8'(4 * i), 32'(16'h0300 - 16'(i * 256)), 2'b00);
    rd_chk(`CIF_OFF_AUX0 + 8'h04, 32'h0000_0200, 2'b00, "aux two");
    check("target main", 32'(target_setpoint), 32'h0500);
    // every handled code on input 0, with its own polarity
    for (int k = 0; k < 11; k++) begin
      c = CODE_LIST[k];
      low = (c == 4'h2) || (c == 4'h4) || (c == 4'h6) || (c == 4'h8) || (c == 4'hF);
      axi_write(`CIF_OFF_CODES, 32'h0, 2'b00);
      cmd <= {2'b00, low};
      repeat (Q) @(posedge clk);
      axi_write(`CIF_OFF_CODES, {28'h0, c}, 2'b00);
      p0 = pulse_cycles;
      cmd <= {2'b00, ~low};
      settle(EARLY, Q, 5'h00, act_flags(c), "assert");
      check("target", 32'(target_setpoint), (c == 4'h3 || c == 4'h4) ? 32'h0300 : 32'h0500);
      check("reset pulse", 32'(pulse_cycles - p0), (c >= 4'h7 && c <= 4'h9) ? 32'h1 : 32'h0);
      cmd <= {2'b00, low};
      if (c <= 4'h2) settle(WEARLY, WQ, act_flags(c), 5'h00, "float release");
      else settle(EARLY, Q, act_flags(c), 5'h00, "release");
    end
    // code 0 everywhere: levels of either kind do nothing
    axi_write(`CIF_OFF_CODES, 32'h0, 2'b00);
    cmd <= 3'b111;
    settle(EARLY, Q, 5'h00, 5'h00, "code zero high");
    cmd <= 3'b000;
    settle(EARLY, Q, 5'h00, 5'h00, "code zero low");
    check("target code zero", 32'(target_setpoint), 32'h0500);
    // short pulses that add up past the time must not qualify
    axi_write(`CIF_OFF_CODES, 32'h001, 2'b00);
    repeat (3) begin
      cmd <= 3'b001;
      repeat (6) @(posedge clk);
      cmd <= 3'b000;
      repeat (4) @(posedge clk);
    end
    repeat (Q) @(posedge clk);
    check("restart on change", 32'(fl), 32'h0);
    multi(32'h101, 5'b10001, 5'b10001, WEARLY, WQ, "float pair");
    multi(32'hE05, 5'b11010, 5'b10010, EARLY, Q, "disable pair");
    // all three inputs on auxiliary setpoints: lowest active value wins
    axi_write(`CIF_OFF_CODES, 32'h333, 2'b00);
    cmd <= 3'b111;
    settle(EARLY, Q, 5'h00, 5'b00100, "aux all");
    check("target lowest", 32'(target_setpoint), 32'h0100);
    rd_chk(`CIF_OFF_STATUS, 32'h0100_0704, 2'b00, "status aux");
    cmd <= 3'b011;
    repeat (Q) @(posedge clk);
    check("target next lowest", 32'(target_setpoint), 32'h0200);
    cmd <= 3'b000;
    settle(EARLY, Q, 5'b00100, 5'h00, "aux none");
    check("target back", 32'(target_setpoint), 32'h0500);
    // byte strobes: only the low lane of the main setpoint may change
    s_axi_wstrb <= 4'h1;
    axi_write(`CIF_OFF_MAIN_SP, 32'h0000_12FF, 2'b00);
    s_axi_wstrb <= 4'hF;
    rd_chk(`CIF_OFF_MAIN_SP, 32'h0000_05FF, 2'b00, "main byte lane");
    check("target main lane", 32'(target_setpoint), 32'h05FF);
    complete_run();
  end
endmodule
`default_nettype wire
